/* apt_params.svh */
// Constants for the ambient and conversion-reset phase timer
`ifndef APT_PARAMS_SVH
`define APT_PARAMS_SVH

`define APT_CLK_SYS_HZ 100000000
`define APT_TIMEBASE_HZ 4000000
`define APT_TB_DIV (`APT_CLK_SYS_HZ / `APT_TIMEBASE_HZ)

`define APT_ADDR_AMB_START 8'h13
`define APT_ADDR_AMB_END 8'h14
`define APT_ADDR_RST0_START 8'h15
`define APT_ADDR_RST0_END 8'h16
`define APT_ADDR_RST1_START 8'h17
`define APT_ADDR_RST1_END 8'h18
`define APT_ADDR_RST2_START 8'h19
`define APT_ADDR_RST2_END 8'h1a
`define APT_ADDR_PERIOD 8'h1d
`define APT_ADDR_CTRL 8'h1e

`define APT_WIN_REGS 8
`define APT_WINDOWS 4
`define APT_CTRL_EN_BIT 8
`define APT_COUNT_RESET 16'h0000
`define APT_ENABLE_RESET 1'b0

`define APT_ADDR_BITS 8
`define APT_DATA_BITS 24

`endif

/* apt_pkg.sv */
// Types shared by the phase timer modules
package apt_pkg;
  typedef logic [15:0] apt_count_t;
  typedef logic [23:0] apt_word_t;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_ADDR = 2'b01,
    SPI_DATA = 2'b11,
    SPI_DONE = 2'b10
  } apt_spi_state_t;
endpackage : apt_pkg

/* apt_tb_if.sv */
// Timebase carrier from the period counter to the phase windows
`timescale 1ns/10ps
`default_nettype none
interface apt_tb_if;
  logic run;
  apt_pkg::apt_count_t count;
  modport src (output run, output count);
  modport snk (input run, input count);
endinterface : apt_tb_if
`default_nettype wire

/* apt_phase_window.sv */
// One phase window: high from its start count through its end count
`timescale 1ns/10ps
`default_nettype none
module apt_phase_window (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timebase
  apt_tb_if.snk tb,
  // Programmed window
  input wire apt_pkg::apt_count_t start_count,
  input wire apt_pkg::apt_count_t end_count,
  // Phase
  output logic phase
);
  logic phase_r;
  logic phase_nxt;

  always_comb begin
    // Inclusive window, gated by the timer enable
    phase_nxt = tb.run && (tb.count >= start_count) && (tb.count <= end_count);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;

  property p_win_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (tb.run && tb.count == start_count && start_count <= end_count) |=> phase_r;
  endproperty
  a_win_start: assert property (p_win_start) else $error("phase not high at start count");

  property p_win_end;
    @(posedge clk_sys) disable iff (!rst_n)
      (tb.run && tb.count > end_count) |=> !phase_r;
  endproperty
  a_win_end: assert property (p_win_end) else $error("phase high after end count");

  property p_win_disabled;
    @(posedge clk_sys) disable iff (!rst_n)
      !tb.run |=> !phase_r;
  endproperty
  a_win_disabled: assert property (p_win_disabled) else $error("phase high while timer disabled");
endmodule : apt_phase_window
`default_nettype wire

/* apt_timer.sv */
// Phase timer top: SPI register slave, period timebase and phase windows
`timescale 1ns/10ps
`default_nettype none
`include "apt_params.svh"
module apt_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // SPI pins
  input wire logic spi_sclk,
  input wire logic spi_ste_n,
  input wire logic spi_simo,
  output logic spi_somi,
  input wire logic spi_read_mode,
  // Phase outputs
  output logic led1_ambient_phase,
  output logic [2:0] conv_reset_phase
);
  localparam logic [4:0] DIV_LAST = 5'(`APT_TB_DIV - 1);
  localparam logic [4:0] ADDR_LAST = 5'(`APT_ADDR_BITS - 1);
  localparam logic [4:0] DATA_LAST = 5'(`APT_DATA_BITS - 1);

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] sclk_sync_r;
  logic [2:0] sclk_sync_nxt;
  logic [1:0] ste_sync_r;
  logic [1:0] ste_sync_nxt;
  logic [1:0] simo_sync_r;
  logic [1:0] simo_sync_nxt;
  logic [1:0] rdm_sync_r;
  logic [1:0] rdm_sync_nxt;

  always_comb begin
    sclk_sync_nxt = {sclk_sync_r[1:0], spi_sclk};
    ste_sync_nxt = {ste_sync_r[0], spi_ste_n};
    simo_sync_nxt = {simo_sync_r[0], spi_simo};
    rdm_sync_nxt = {rdm_sync_r[0], spi_read_mode};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_r <= 3'h0;
      ste_sync_r <= 2'h3;
      simo_sync_r <= 2'h0;
      rdm_sync_r <= 2'h0;
    end else begin
      sclk_sync_r <= sclk_sync_nxt;
      ste_sync_r <= ste_sync_nxt;
      simo_sync_r <= simo_sync_nxt;
      rdm_sync_r <= rdm_sync_nxt;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic ste_n_s;
  logic simo_s;
  logic read_mode_s;
  assign sclk_rise = sclk_sync_r[1] && !sclk_sync_r[2];
  assign sclk_fall = !sclk_sync_r[1] && sclk_sync_r[2];
  assign ste_n_s = ste_sync_r[1];
  assign simo_s = simo_sync_r[1];
  assign read_mode_s = rdm_sync_r[1];

  // Register file
  apt_pkg::apt_count_t win_r [`APT_WIN_REGS];
  apt_pkg::apt_count_t win_nxt [`APT_WIN_REGS];
  apt_pkg::apt_count_t period_r;
  apt_pkg::apt_count_t period_nxt;
  logic enable_r;
  logic enable_nxt;
  logic wr_en;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  apt_pkg::apt_word_t in_sh_r;
  apt_pkg::apt_word_t in_sh_nxt;
  apt_pkg::apt_count_t wr_data;
  logic [7:0] win_idx;

  // Upper byte of a write is dropped; only the count is kept
  assign wr_data = {in_sh_r[14:0], simo_s};
  assign win_idx = addr_r - `APT_ADDR_AMB_START;

  always_comb begin
    win_nxt = win_r;
    period_nxt = period_r;
    enable_nxt = enable_r;
    if (wr_en) begin
      if (addr_r >= `APT_ADDR_AMB_START && addr_r <= `APT_ADDR_RST2_END) begin
        win_nxt[win_idx[2:0]] = wr_data;
      end else if (addr_r == `APT_ADDR_PERIOD) begin
        period_nxt = wr_data;
      end else if (addr_r == `APT_ADDR_CTRL) begin
        enable_nxt = wr_data[`APT_CTRL_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `APT_WIN_REGS; i++) begin
        win_r[i] <= `APT_COUNT_RESET;
      end
      period_r <= `APT_COUNT_RESET;
      enable_r <= `APT_ENABLE_RESET;
    end else begin
      win_r <= win_nxt;
      period_r <= period_nxt;
      enable_r <= enable_nxt;
    end
  end

  function automatic apt_pkg::apt_word_t read_value(input logic [7:0] a);
    apt_pkg::apt_word_t v;
    logic [7:0] idx;
    v = 24'h000000;
    idx = a - `APT_ADDR_AMB_START;
    if (a >= `APT_ADDR_AMB_START && a <= `APT_ADDR_RST2_END) begin
      v = {8'h00, win_r[idx[2:0]]};
    end else if (a == `APT_ADDR_PERIOD) begin
      v = {8'h00, period_r};
    end else if (a == `APT_ADDR_CTRL) begin
      v[`APT_CTRL_EN_BIT] = enable_r;
    end
    return v;
  endfunction : read_value

  // SPI frame: 8 address bits then 24 data bits, MSB first
  apt_pkg::apt_spi_state_t spi_state_r;
  apt_pkg::apt_spi_state_t spi_state_nxt;
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  apt_pkg::apt_word_t out_sh_r;
  apt_pkg::apt_word_t out_sh_nxt;
  logic somi_r;
  logic somi_nxt;
  logic reading_r;
  logic reading_nxt;

  always_comb begin
    spi_state_nxt = spi_state_r;
    bit_cnt_nxt = bit_cnt_r;
    in_sh_nxt = in_sh_r;
    addr_nxt = addr_r;
    out_sh_nxt = out_sh_r;
    reading_nxt = reading_r;
    wr_en = 1'b0;
    if (ste_n_s) begin
      spi_state_nxt = apt_pkg::SPI_IDLE;
      bit_cnt_nxt = 5'h00;
      reading_nxt = 1'b0;
    end else begin
      case (spi_state_r)
        apt_pkg::SPI_IDLE: begin
          spi_state_nxt = apt_pkg::SPI_ADDR;
          bit_cnt_nxt = 5'h00;
        end
        apt_pkg::SPI_ADDR: begin
          if (sclk_rise) begin
            in_sh_nxt = {in_sh_r[22:0], simo_s};
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == ADDR_LAST) begin
              addr_nxt = {in_sh_r[6:0], simo_s};
              out_sh_nxt = read_value({in_sh_r[6:0], simo_s});
              reading_nxt = read_mode_s;
              bit_cnt_nxt = 5'h00;
              spi_state_nxt = apt_pkg::SPI_DATA;
            end
          end
        end
        apt_pkg::SPI_DATA: begin
          if (sclk_rise) begin
            in_sh_nxt = {in_sh_r[22:0], simo_s};
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == DATA_LAST) begin
              wr_en = !reading_r;
              spi_state_nxt = apt_pkg::SPI_DONE;
            end
          end else if (sclk_fall && bit_cnt_r != 5'h00) begin
            out_sh_nxt = {out_sh_r[22:0], 1'b0};
          end
        end
        apt_pkg::SPI_DONE: begin
          // Extra clocks are ignored until select rises
          spi_state_nxt = apt_pkg::SPI_DONE;
        end
        default: begin
          spi_state_nxt = apt_pkg::SPI_IDLE;
        end
      endcase
    end
    somi_nxt = reading_nxt && (spi_state_nxt == apt_pkg::SPI_DATA) && out_sh_nxt[23];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spi_state_r <= apt_pkg::SPI_IDLE;
      bit_cnt_r <= 5'h00;
      in_sh_r <= 24'h000000;
      addr_r <= 8'h00;
      out_sh_r <= 24'h000000;
      somi_r <= 1'b0;
      reading_r <= 1'b0;
    end else begin
      spi_state_r <= spi_state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      in_sh_r <= in_sh_nxt;
      addr_r <= addr_nxt;
      out_sh_r <= out_sh_nxt;
      somi_r <= somi_nxt;
      reading_r <= reading_nxt;
    end
  end

  assign spi_somi = somi_r;

  // Timebase: 4 MHz tick from the system clock, period counter on the tick
  logic [4:0] presc_r;
  logic [4:0] presc_nxt;
  apt_pkg::apt_count_t cnt_r;
  apt_pkg::apt_count_t cnt_nxt;
  logic tick;
  assign tick = enable_r && (presc_r == DIV_LAST);

  always_comb begin
    presc_nxt = 5'h00;
    cnt_nxt = 16'h0000;
    if (enable_r) begin
      presc_nxt = tick ? 5'h00 : presc_r + 5'h01;
      cnt_nxt = cnt_r;
      if (tick) begin
        cnt_nxt = (cnt_r >= period_r) ? 16'h0000 : cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= 5'h00;
      cnt_r <= 16'h0000;
    end else begin
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  apt_tb_if tbus ();
  assign tbus.run = enable_r;
  assign tbus.count = cnt_r;

  logic [3:0] phase_w;
  for (genvar g = 0; g < `APT_WINDOWS; g++) begin : g_win
    apt_phase_window u_win (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tb(tbus.snk),
      .start_count(win_r[2 * g]),
      .end_count(win_r[2 * g + 1]),
      .phase(phase_w[g])
    );
  end

  assign led1_ambient_phase = phase_w[0];
  assign conv_reset_phase = phase_w[3:1];

  // Checks
  logic wrote_any_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrote_any_r <= 1'b0;
    end else begin
      wrote_any_r <= wrote_any_r || wr_en;
    end
  end

  property p_reset_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      !wrote_any_r |-> (win_r[0] == 16'h0000 && win_r[3] == 16'h0000 && win_r[7] == 16'h0000 && period_r == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("count not zero before first write");

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && cnt_r == period_r) |=> (cnt_r == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("timebase did not wrap at period");

  property p_step;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && cnt_r < period_r) |=> (cnt_r == $past(cnt_r) + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("timebase did not advance on tick");

  sequence s_tick_gap;
    !tick [*8];
  endsequence
  property p_tick_rate;
    @(posedge clk_sys) disable iff (!rst_n)
      tick |=> s_tick_gap;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("timebase tick too frequent");

  property p_disabled_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !enable_r |=> (cnt_r == 16'h0000 && !tick);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("timebase running while disabled");

  sequence s_period_write;
    wr_en && addr_r == `APT_ADDR_PERIOD;
  endsequence
  property p_period_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_period_write |=> (period_r == $past(wr_data));
  endproperty
  a_period_write: assert property (p_period_write) else $error("period write not stored");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (enable_r && !tick) |=> $stable(cnt_r);
  endproperty
  a_hold: assert property (p_hold) else $error("timebase moved without tick");

  property p_enable_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && addr_r == `APT_ADDR_CTRL) |=> (enable_r == $past(wr_data[`APT_CTRL_EN_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not stored");
endmodule : apt_timer
`default_nettype wire

/* apt_host_model.sv */
// Host model: SPI master that programs the phase timer registers
`timescale 1ns/10ps
`default_nettype none
module apt_host_model (
  // Clock
  input wire logic clk_sys,
  // SPI pins driven by the host
  output logic spi_sclk,
  output logic spi_ste_n,
  output logic spi_simo,
  output logic spi_read_mode,
  // SPI data back from the timer
  input wire logic spi_somi
);
  // Half period of sclk in clk_sys cycles; the slave needs at least 4
  localparam int HALF = 5;

  initial begin
    spi_sclk = 1'b0;
    spi_ste_n = 1'b1;
    spi_simo = 1'b0;
    spi_read_mode = 1'b0;
  end

  // One whole frame: address byte, then 24 data bits, MSB first
  task automatic xfer(input logic [7:0] addr, input apt_pkg::apt_word_t wdata, input logic rd,
                      output apt_pkg::apt_word_t rdata);
    logic [31:0] frame;
    frame = {addr, wdata};
    rdata = '0;
    @(posedge clk_sys);
    spi_ste_n <= 1'b0;
    spi_read_mode <= rd;
    for (int i = 0; i < 32; i++) begin
      spi_simo <= frame[31 - i];
      repeat (HALF) @(posedge clk_sys);
      // Read bits move a few cycles after each fall and drop once the last rise is seen,
      // so each one is taken as sclk rises, on the nine-th to the last rise
      if (i >= 8) begin
        rdata = {rdata[22:0], spi_somi};
      end
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    spi_ste_n <= 1'b1;
    // Released data line must not keep showing the last bit
    spi_simo <= ~frame[0];
    repeat (HALF) @(posedge clk_sys);
  endtask : xfer

  task automatic wr(input logic [7:0] addr, input apt_pkg::apt_count_t count);
    apt_pkg::apt_word_t unused;
    xfer(addr, {8'h00, count}, 1'b0, unused);
  endtask : wr
endmodule : apt_host_model
`default_nettype wire

/* apt_timer_bench.sv */
// Self-checking bench for the phase timer
`timescale 1ns/10ps
`default_nettype none
`include "apt_params.svh"
module apt_timer_bench;
  localparam int DIV = `APT_TB_DIV;
  localparam int PER = 39;
  logic clk_sys;
  logic rst_n;
  logic spi_sclk;
  logic spi_ste_n;
  logic spi_simo;
  logic spi_read_mode;
  logic spi_somi;
  logic led1_ambient_phase;
  logic [2:0] conv_reset_phase;
  logic [3:0] ph;
  logic [3:0] ph_q = 4'h0;
  logic [7:0] addrs [8] = '{`APT_ADDR_AMB_START, `APT_ADDR_AMB_END, `APT_ADDR_RST0_START, `APT_ADDR_RST0_END,
                            `APT_ADDR_RST1_START, `APT_ADDR_RST1_END, `APT_ADDR_RST2_START, `APT_ADDR_RST2_END};
  // Start/end pairs; reset window zero is one tick at 0 and reset window two sits on the last count
  int c [8] = '{2, 5, 0, 0, 10, 12, 39, 39};
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rise_t [4] = '{default: 0};
  int width [4] = '{default: 0};
  int per [4] = '{default: 0};

  assign ph = {conv_reset_phase, led1_ambient_phase};

  apt_timer u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .spi_sclk(spi_sclk),
    .spi_ste_n(spi_ste_n),
    .spi_simo(spi_simo),
    .spi_somi(spi_somi),
    .spi_read_mode(spi_read_mode),
    .led1_ambient_phase(led1_ambient_phase),
    .conv_reset_phase(conv_reset_phase)
  );

  apt_host_model u_host (
    .clk_sys(clk_sys),
    .spi_sclk(spi_sclk),
    .spi_ste_n(spi_ste_n),
    .spi_simo(spi_simo),
    .spi_read_mode(spi_read_mode),
    .spi_somi(spi_somi)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Edge times of every phase, in clk_sys cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ph_q <= ph;
    for (int k = 0; k < 4; k++) begin
      if (ph[k] && !ph_q[k]) begin
        per[k] <= cyc - rise_t[k];
        rise_t[k] <= cyc;
      end
      if (!ph[k] && ph_q[k]) begin
        width[k] <= cyc - rise_t[k];
      end
    end
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] addr, input logic [23:0] exp);
    apt_pkg::apt_word_t got;
    u_host.xfer(addr, 24'h000000, 1'b1, got);
    check($sformatf("reg %h", addr), exp, got);
  endtask : rd_chk

  // Longer than one whole period, so any stray window would show
  task automatic idle_chk();
    repeat (1100) begin
      @(posedge clk_sys);
      check("phases", 24'h000000, {20'h00000, ph});
    end
  endtask : idle_chk

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    $display("FAIL watchdog expected done seen timeout");
    results();
  end

  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) rd_chk(addrs[i], 24'h000000);
    for (int i = 0; i < 8; i++) u_host.wr(addrs[i], 16'(c[i]));
    u_host.wr(`APT_ADDR_PERIOD, 16'(PER));
    for (int i = 0; i < 8; i++) rd_chk(addrs[i], 24'(c[i]));
    rd_chk(`APT_ADDR_PERIOD, 24'(PER));
    rd_chk(8'h1f, 24'h000000);
    idle_chk();
    u_host.wr(`APT_ADDR_CTRL, 16'h0100);
    rd_chk(`APT_ADDR_CTRL, 24'h000100);
    repeat (3 * (PER + 1) * DIV) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      check($sformatf("width %0d", k), 24'((c[2*k+1] - c[2*k] + 1) * DIV), 24'(width[k]));
      check($sformatf("period %0d", k), 24'((PER + 1) * DIV), 24'(per[k]));
      check($sformatf("offset %0d", k), 24'(((c[2*k] - c[0]) * DIV + (PER + 1) * DIV) % ((PER + 1) * DIV)),
            24'((rise_t[k] - rise_t[0] + 4 * (PER + 1) * DIV) % ((PER + 1) * DIV)));
    end
    u_host.wr(`APT_ADDR_CTRL, 16'h0000);
    idle_chk();
    results();
  end
endmodule : apt_timer_bench
`default_nettype wire
